// File: src/ifc_flow_ctrl.sv
// in-band flow control for one serial channel with its register slave
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ifc_flow_ctrl
  import ifc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_char_err,
  output logic             rxf_wr,
  output logic [7:0]       rxf_data,
  output logic             rx_exc_req,
  input  wire logic        tx_fifo_valid,
  input  wire logic [7:0]  tx_fifo_data,
  output logic             tx_fifo_ready,
  output logic             tx_shift_valid,
  output logic [7:0]       tx_shift_data,
  input  wire logic        tx_shift_ready
);
  logic [7:0]     resume_char_reg;
  logic [7:0]     stop_char_reg;
  logic [7:0]     option_reg_2;
  logic [7:0]     option_reg_3;
  logic [7:0]     option_reg_5;
  logic           rx_en;
  logic           tx_en;
  logic           rx_stop_sent_flag;
  logic           rx_resume_sent_flag;
  logic           tx_stopped_flag;
  logic           tx_resume_pending_flag;
  logic           resume_on_line;
  logic           sc1_pend;
  logic           sc2_pend;
  logic           hold_full;
  logic [7:0]     hold_data;
  logic           aw_held;
  logic           w_held;
  logic [7:0]     aw_addr;
  logic [31:0]    w_data;
  logic [3:0]     w_strb;
  logic [7:0]     exc_char;
  ifc_rxf_state_t rxf_state;
  logic           hit_resume;
  logic           hit_stop;

  // write channel: address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire        aw_take  = s_axi_awvalid && s_axi_awready;
  wire        w_take   = s_axi_wvalid && s_axi_wready;
  wire [7:0]  wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb;
  wire        wr_fire  = (aw_held || aw_take) && (w_held || w_take);
  wire        wr_lane  = wr_fire && wr_strb[0];
  wire        wr_known = (wr_addr <= ADDR_OPT5) && (wr_addr[1:0] == 2'h0);
  wire        wr_cmd   = wr_lane && (wr_addr == ADDR_CMD);

  // command pulses, one cycle each
  wire cmd_sc1    = wr_cmd && wr_data[CMD_SEND_SC1];
  wire cmd_sc2    = wr_cmd && wr_data[CMD_SEND_SC2];
  wire cmd_rx_on  = wr_cmd && wr_data[CMD_RX_EN];
  wire cmd_rx_off = wr_cmd && wr_data[CMD_RX_DIS];
  wire cmd_tx_on  = wr_cmd && wr_data[CMD_TX_EN];
  wire cmd_tx_off = wr_cmd && wr_data[CMD_TX_DIS];
  wire rx_toggle  = cmd_rx_on || cmd_rx_off;
  wire tx_toggle  = cmd_tx_on || cmd_tx_off;

  // write-side holding and response
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      aw_held <= !wr_fire && (aw_held || aw_take);
      w_held  <= !wr_fire && (w_held || w_take);
      if (aw_take)
        aw_addr <= s_axi_awaddr;
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // option and character registers; any byte value is legal
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resume_char_reg <= CHAR_RST;
      stop_char_reg   <= CHAR_RST;
      option_reg_2    <= OPT2_RST;
      option_reg_3    <= OPT3_RST;
      option_reg_5    <= OPT5_RST;
    end
    else if (wr_lane)
    begin
      if (wr_addr == ADDR_RESUME)
        resume_char_reg <= wr_data[7:0]; // see R1
      if (wr_addr == ADDR_STOP)
        stop_char_reg <= wr_data[7:0]; // see R1
      if (wr_addr == ADDR_OPT2)
        option_reg_2 <= wr_data[7:0];
      if (wr_addr == ADDR_OPT3)
        option_reg_3 <= wr_data[7:0];
      if (wr_addr == ADDR_OPT5)
        option_reg_5 <= wr_data[7:0];
    end
  end

  // read decode; the command word reads back as zero
  wire [7:0] channel_ctrl_status_reg = {2'b00, tx_resume_pending_flag, tx_stopped_flag, tx_en,
                     rx_resume_sent_flag, rx_stop_sent_flag, rx_en};
  wire       rd_known = (s_axi_araddr <= ADDR_OPT5) && (s_axi_araddr[1:0] == 2'h0);
  wire [7:0] rd_byte  = (s_axi_araddr == ADDR_RESUME) ? resume_char_reg :
                        (s_axi_araddr == ADDR_STOP)   ? stop_char_reg :
                        (s_axi_araddr == ADDR_CHANNEL_CTRL_STATUS_REG)   ? channel_ctrl_status_reg :
                        (s_axi_araddr == ADDR_OPT2)   ? option_reg_2 :
                        (s_axi_araddr == ADDR_OPT3)   ? option_reg_3 :
                        (s_axi_araddr == ADDR_OPT5)   ? option_reg_5 : 8'h00;
  assign s_axi_arready = !s_axi_rvalid;

  // read answer one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // comparators against both programmed characters
  ifc_char_match u_match_resume (
    .char_in  (rx_char),
    .ref_char (resume_char_reg),
    .char_len (option_reg_3[OPT3_LEN_LO +: 2]),
    .match    (hit_resume)
  );
  ifc_char_match u_match_stop (
    .char_in  (rx_char),
    .ref_char (stop_char_reg),
    .char_len (option_reg_3[OPT3_LEN_LO +: 2]),
    .match    (hit_stop)
  );

  // receive classification; stop wins if both registers hold the same value
  wire auto_tx    = option_reg_2[OPT2_AUTO_TX];
  wire detect_on  = option_reg_3[OPT3_DETECT] && auto_tx; // see R11
  wire transp     = option_reg_3[OPT3_TRANSP];
  wire rx_take    = rx_char_valid && rx_en; // see R10
  wire err_ok     = !rx_char_err || option_reg_5[OPT5_ERR_MATCH]; // see R13
  wire can_match  = rx_take && detect_on && err_ok;
  wire is_stop    = can_match && hit_stop;
  wire is_resume  = can_match && hit_resume && !hit_stop;
  wire is_flow    = is_stop || is_resume;
  // only resume restarts unless implied mode lets any character but a stop match do it
  wire implied    = rx_take && auto_tx && option_reg_2[OPT2_IMPLIED] && !is_stop; // see R14
  wire restart    = is_resume || (implied && tx_stopped_flag); // see R15

  // transmit path: holding char first, then stop, then resume, then queued data
  wire send_hold  = hold_full && tx_en;
  wire send_sc2   = !send_hold && sc2_pend;
  wire send_sc1   = !send_hold && !sc2_pend && sc1_pend;
  assign tx_shift_valid = send_hold || sc1_pend || sc2_pend; // see R5
  assign tx_shift_data  = send_hold ? hold_data :
                          send_sc2  ? stop_char_reg : resume_char_reg; // see R2 see R3 see R4
  wire shift_take = tx_shift_valid && tx_shift_ready;
  wire hold_take  = shift_take && send_hold;
  wire sc1_gone   = shift_take && send_sc1;
  wire sc2_gone   = shift_take && send_sc2;
  // a halt stops refilling; the holding char still drains
  assign tx_fifo_ready = tx_en && !tx_stopped_flag && !hold_full; // see R12
  wire fifo_load  = tx_fifo_valid && tx_fifo_ready;

  // holding register and pending special characters; new commands win
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_full <= 1'b0;
      hold_data <= 8'h00;
      sc1_pend  <= 1'b0;
      sc2_pend  <= 1'b0;
    end
    else
    begin
      hold_full <= fifo_load || (hold_full && !hold_take);
      if (fifo_load)
        hold_data <= tx_fifo_data;
      sc1_pend <= cmd_sc1 || (sc1_pend && !sc1_gone);
      sc2_pend <= cmd_sc2 || (sc2_pend && !sc2_gone);
    end
  end

  // enables and receive-side flags; command sets win over clears, except send-resume clearing stop-sent beats send-stop
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_en               <= 1'b0;
      tx_en               <= 1'b0;
      rx_stop_sent_flag   <= 1'b0;
      rx_resume_sent_flag <= 1'b0;
      resume_on_line      <= 1'b0;
    end
    else
    begin
      if (rx_toggle)
        rx_en <= cmd_rx_on;
      if (tx_toggle)
        tx_en <= cmd_tx_on;
      if (cmd_sc1)
        rx_stop_sent_flag <= 1'b0; // see R7
      else if (cmd_sc2)
        rx_stop_sent_flag <= 1'b1; // see R6
      else if (rx_toggle)
        rx_stop_sent_flag <= 1'b0; // see R9
      if (cmd_sc1)
        rx_resume_sent_flag <= 1'b1; // see R7
      else if (cmd_sc2 || rx_toggle || (rx_take && resume_on_line))
        rx_resume_sent_flag <= 1'b0; // see R8 see R9
      resume_on_line <= sc1_gone || (resume_on_line && !cmd_sc1 && rx_resume_sent_flag && !rx_take);
    end
  end

  // transmit-side flags; a match in the toggle cycle still counts
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_stopped_flag        <= 1'b0;
      tx_resume_pending_flag <= 1'b0;
    end
    else
    begin
      if (is_stop)
        tx_stopped_flag <= 1'b1; // see R16
      else if (restart || tx_toggle)
        tx_stopped_flag <= 1'b0; // see R17 see R18
      if (is_resume)
        tx_resume_pending_flag <= 1'b1; // see R17
      else if (is_stop || tx_toggle || fifo_load)
        tx_resume_pending_flag <= 1'b0; // see R17 see R18
    end
  end

  // receive FIFO writer; an exception takes two cycles, so chars need a gap
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxf_state  <= RXF_IDLE;
      rxf_wr     <= 1'b0;
      rxf_data   <= 8'h00;
      rx_exc_req <= 1'b0;
      exc_char   <= 8'h00;
    end
    else
    begin
      rxf_wr     <= 1'b0;
      rx_exc_req <= 1'b0;
      case (rxf_state)
        RXF_IDLE:
        begin
          if (rx_take && is_flow && !transp) // see R19 see R20
          begin
            rxf_wr     <= 1'b1;
            rxf_data   <= is_stop ? EXC_STOP : EXC_RESUME; // see R21
            rx_exc_req <= 1'b1; // see R19
            exc_char   <= rx_char;
            rxf_state  <= RXF_CHAR;
          end
          else if (rx_take && !is_flow)
          begin
            rxf_wr   <= 1'b1;
            rxf_data <= rx_char;
          end
        end
        RXF_CHAR:
        begin
          rxf_wr    <= 1'b1;
          rxf_data  <= exc_char; // see R21
          rxf_state <= RXF_IDLE;
        end
        default:
          rxf_state <= RXF_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_exc_start;
    rxf_state == RXF_IDLE && rx_take && is_flow && !transp;
  endsequence
  sequence s_exc_bytes;
    rxf_wr && rx_exc_req ##1 rxf_wr && !rx_exc_req && rxf_data == $past(rx_char, 2);
  endsequence

  property p_stop_cmd;
    cmd_sc2 && !cmd_sc1 |=> rx_stop_sent_flag && !rx_resume_sent_flag;
  endproperty
  a_stop_cmd: assert property (p_stop_cmd) else $error("stop command did not set flag"); // see R6

  property p_resume_cmd;
    cmd_sc1 |=> rx_resume_sent_flag && !rx_stop_sent_flag;
  endproperty
  a_resume_cmd: assert property (p_resume_cmd) else $error("resume command flags wrong"); // see R7

  property p_resume_seen;
    rx_resume_sent_flag && resume_on_line && rx_take && !cmd_sc1 |=> !rx_resume_sent_flag;
  endproperty
  a_resume_seen: assert property (p_resume_seen) else $error("resume-sent flag held after reception"); // see R8

  property p_rx_toggle;
    rx_toggle && !wr_data[CMD_SEND_SC1] && !wr_data[CMD_SEND_SC2] |=> !rx_stop_sent_flag && !rx_resume_sent_flag;
  endproperty
  a_rx_toggle: assert property (p_rx_toggle) else $error("receive flags survived enable change"); // see R9

  property p_no_match_off;
    rx_take && !detect_on && !tx_stopped_flag |=> !tx_stopped_flag;
  endproperty
  a_no_match_off: assert property (p_no_match_off) else $error("halt without detection enabled"); // see R11

  property p_stop_halts;
    is_stop |=> tx_stopped_flag && !tx_fifo_ready ##1 !tx_fifo_ready || !tx_stopped_flag;
  endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("stop match did not halt"); // see R12

  property p_special_halted;
    tx_stopped_flag && sc2_pend && !hold_full |-> tx_shift_valid && tx_shift_data == stop_char_reg;
  endproperty
  a_special_halted: assert property (p_special_halted) else $error("stop char blocked by halt"); // see R5

  property p_implied;
    implied && tx_stopped_flag && !tx_toggle |=> !tx_stopped_flag;
  endproperty
  a_implied: assert property (p_implied) else $error("implied resume did not restart"); // see R15

  property p_exc;
    s_exc_start |=> s_exc_bytes;
  endproperty
  a_exc: assert property (p_exc) else $error("exception entry not two bytes"); // see R21

  property p_transp;
    rxf_state == RXF_IDLE && is_flow && transp |=> !rxf_wr;
  endproperty
  a_transp: assert property (p_transp) else $error("flow char stored in transparent mode"); // see R20

  property p_tx_flags_excl;
    !(tx_stopped_flag && tx_resume_pending_flag) && !(rx_stop_sent_flag && rx_resume_sent_flag);
  endproperty
  a_tx_flags_excl: assert property (p_tx_flags_excl) else $error("unused flag encoding seen"); // see R17
endmodule : ifc_flow_ctrl

// File: src/ifc_pkg.sv
// constants, encodings and register map for the in-band flow control block
// Notes on behaviour
// R1: resume and stop characters are software registers accepting any byte value.
// R2: send-stop command transmits the stop-character register value.
// R3: commanded character goes after shifting and holding characters, ahead of queued data.
// R4: send-resume command transmits the resume-character register value.
// R5: send commands work even while the transmitter is halted remotely.
// R6: send-stop command sets the receive-stop-sent flag.
// R7: send-resume command sets receive-resume-sent and clears receive-stop-sent.
// R8: receive-resume-sent clears on the first character received after the resume went out.
// R9: receiver enable or disable clears both receive flags; both set is unused.
// R10: receiver keeps accepting characters whatever the stop-sent flag says.
// R11: matching only when detection and automatic transmit control are both on.
// R12: stop match halts transmitter after current and holding characters.
// R13: error-match option also lets characters with errors match.
// R14: without implied resume only the resume character restarts; others stored normally.
// R15: with implied resume any received character restarts a halted transmitter; the code excepts a stop match, which keeps it halted.
// R16: stop match with automatic control sets the transmit-stopped flag.
// R17: resume match sets resume-pending, clears stopped; pending clears when sending restarts.
// R18: transmitter enable or disable clears both transmit flags and releases the halt.
// R19: without transparency matched characters go to the FIFO with an exception request.
// R20: with transparency matched characters still steer transmission but are discarded.
// R21: exception entry is two FIFO bytes: status first, then the character.
// R22: match compares whole character at configured length, once per character.
package ifc_pkg;
  // byte addresses of the register words
  localparam logic [7:0] ADDR_RESUME = 8'h00;
  localparam logic [7:0] ADDR_STOP   = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_CHANNEL_CTRL_STATUS_REG   = 8'h0C;
  localparam logic [7:0] ADDR_OPT2   = 8'h10;
  localparam logic [7:0] ADDR_OPT3   = 8'h14;
  localparam logic [7:0] ADDR_OPT5   = 8'h18;
  // command bits, write-only pulses
  localparam int CMD_SEND_SC1 = 0;
  localparam int CMD_SEND_SC2 = 1;
  localparam int CMD_RX_EN    = 2;
  localparam int CMD_RX_DIS   = 3;
  localparam int CMD_TX_EN    = 4;
  localparam int CMD_TX_DIS   = 5;
  // status bits
  localparam int CS_RX_EN     = 0;
  localparam int CS_RX_STOP   = 1;
  localparam int CS_RX_RESUME = 2;
  localparam int CS_TX_EN     = 3;
  localparam int CS_TX_STOP   = 4;
  localparam int CS_TX_RESUME = 5;
  // option fields
  localparam int OPT2_AUTO_TX   = 6;
  localparam int OPT2_IMPLIED   = 7;
  localparam int OPT3_LEN_LO    = 0;
  localparam int OPT3_DETECT    = 4;
  localparam int OPT3_TRANSP    = 5;
  localparam int OPT5_ERR_MATCH = 0;
  // reset values
  localparam logic [7:0] CHAR_RST = 8'h00;
  localparam logic [7:0] OPT2_RST = 8'h00;
  localparam logic [7:0] OPT3_RST = 8'h03;
  localparam logic [7:0] OPT5_RST = 8'h00;
  // exception status bytes
  localparam logic [7:0] EXC_STOP   = 8'h01;
  localparam logic [7:0] EXC_RESUME = 8'h02;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // receive FIFO writer states
  typedef enum logic {RXF_IDLE, RXF_CHAR} ifc_rxf_state_t;
endpackage : ifc_pkg

// File: src/ifc_char_match.sv
// compares a received character with a programmed one at the active length
`timescale 1ns/1ps
module ifc_char_match
  import ifc_pkg::*;
(
  input  wire logic [7:0] char_in,
  input  wire logic [7:0] ref_char,
  input  wire logic [1:0] char_len,
  output logic            match
);
  // length code 0..3 means 5..8 data bits; unused upper bits never count
  wire [7:0] len_mask = 8'hFF >> (2'h3 - char_len);

  // whole character compared, not a partial field
  assign match = ((char_in ^ ref_char) & len_mask) == 8'h00; // see R22
endmodule : ifc_char_match

// File: tb/ifc_remote_model.sv
// remote serial partner taking characters from the transmit shifter
`timescale 1ns/1ps
module ifc_remote_model
  import ifc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       stall,
  input  wire logic       slow,
  input  wire logic       tx_shift_valid,
  input  wire logic [7:0] tx_shift_data,
  output logic            tx_shift_ready
);
  logic [7:0] sent[$];
  logic [1:0] pace;

  initial
  begin
    tx_shift_ready = 1'b0;
    pace = 2'h0;
  end

  // slow mode opens the shifter one cycle in three; a stalled remote never does
  always @(posedge clk_sys)
  begin
    if (tx_shift_valid === 1'b1 && tx_shift_ready)
      sent.push_back(tx_shift_data);
    pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
    tx_shift_ready <= !stall && (!slow || pace == 2'h0);
  end
endmodule : ifc_remote_model

// File: tb/tb_ifc_flow_ctrl.sv
// self-checking bench for the in-band flow control block
`timescale 1ns/1ps
module tb_ifc_flow_ctrl
  import ifc_pkg::*;
;
  logic        clk_sys, reset_n, awvalid, wvalid, bready, arvalid, rready, stall, slow;
  logic        awready, wready, bvalid, arready, rvalid, rx_char_valid, rx_char_err;
  logic        rxf_wr, rx_exc_req, tx_fifo_valid, tx_fifo_ready, tx_shift_valid, tx_shift_ready;
  logic [7:0]  awaddr, araddr, rx_char, rxf_data, tx_fifo_data, tx_shift_data;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [8:0]  rxq[$];
  int          fails, check_count, n;

  ifc_flow_ctrl dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_char_err(rx_char_err), .rxf_wr(rxf_wr), .rxf_data(rxf_data),
    .rx_exc_req(rx_exc_req), .tx_fifo_valid(tx_fifo_valid), .tx_fifo_data(tx_fifo_data),
    .tx_fifo_ready(tx_fifo_ready), .tx_shift_valid(tx_shift_valid), .tx_shift_data(tx_shift_data),
    .tx_shift_ready(tx_shift_ready));

  ifc_remote_model rm (
    .clk_sys(clk_sys), .stall(stall), .slow(slow), .tx_shift_valid(tx_shift_valid),
    .tx_shift_data(tx_shift_data), .tx_shift_ready(tx_shift_ready));

  // 100 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // every receive FIFO write is logged with its exception marker
  always @(posedge clk_sys)
    if (rxf_wr === 1'b1) rxq.push_back({rx_exc_req, rxf_data});

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // no fixed latency assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge clk_sys);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp, "read data");
    chk(rresp, er, "read response");
  endtask : rdc

  task automatic st(input logic [5:0] e);
    rdc(ADDR_CHANNEL_CTRL_STATUS_REG, {26'h0, e}, RESP_OKAY);
  endtask : st

  task automatic cmd(input logic [7:0] c);
    wr(ADDR_CMD, c, RESP_OKAY);
  endtask : cmd

  // characters kept three idle cycles apart so an exception pair never collides
  task automatic rx(input logic [7:0] c, input logic e);
    @(posedge clk_sys);
    rx_char       <= c;
    rx_char_err   <= e;
    rx_char_valid <= 1'b1;
    @(posedge clk_sys);
    rx_char_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : rx

  task automatic rq(input int c, input logic [8:0] e0, input logic [8:0] e1);
    chk(32'(rxq.size()), c, "fifo write count");
    if (c > 0) chk(rxq[0], e0, "first fifo byte");
    if (c > 1) chk(rxq[1], e1, "second fifo byte");
    rxq.delete();
  endtask : rq

  task automatic wait_sent(input int c);
    for (int k = 0; k < 100 && rm.sent.size() < c; k++) @(posedge clk_sys);
    chk(rm.sent.size() >= c, 1, "characters sent");
  endtask : wait_sent

  task automatic t_regs;
    rdc(ADDR_OPT3, {24'h0, OPT3_RST}, RESP_OKAY);
    wr(ADDR_STOP, 8'hFF, RESP_OKAY);
    rdc(ADDR_STOP, 32'h0000_00FF, RESP_OKAY);
    wr(ADDR_RESUME, 8'h11, RESP_OKAY);
    wr(ADDR_STOP, 8'h13, RESP_OKAY);
    rdc(ADDR_RESUME, 32'h0000_0011, RESP_OKAY);
    rdc(ADDR_CMD, 32'h0, RESP_OKAY);
    wr(8'h1C, 8'h5A, RESP_SLVERR);
    rdc(8'h1C, 32'h0, RESP_SLVERR);
    st(6'h00);
  endtask : t_regs

  // transmitter stays disabled: commanded characters must still go out
  task automatic t_send;
    slow <= 1'b1;
    cmd(8'h04);
    cmd(8'h02);
    wait_sent(1);
    chk(rm.sent[0], 8'h13, "stop char sent");
    st(6'b000011);
    rx(8'h41, 1'b0);
    rq(1, 9'h041, 9'h0);
    cmd(8'h01);
    wait_sent(2);
    chk(rm.sent[1], 8'h11, "resume char sent");
    st(6'b000101);
    rx(8'h42, 1'b0);
    rq(1, 9'h042, 9'h0);
    st(6'b000001);
    cmd(8'h02);
    wait_sent(3);
    cmd(8'h08);
    st(6'b000000);
    cmd(8'h04);
    slow <= 1'b0;
  endtask : t_send

  // remote stalled with holding full, then stop command jumps the queue
  task automatic t_pre;
    stall         <= 1'b1;
    tx_fifo_data  <= 8'h55;
    tx_fifo_valid <= 1'b1;
    cmd(8'h10);
    repeat (4) @(posedge clk_sys);
    n = rm.sent.size();
    cmd(8'h02);
    stall <= 1'b0;
    wait_sent(n + 2);
    chk(rm.sent[n], 8'h55, "holding char first");
    chk(rm.sent[n + 1], 8'h13, "stop ahead of fifo");
    tx_fifo_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : t_pre

  task automatic t_auto;
    wr(ADDR_OPT2, 8'h40, RESP_OKAY);
    wr(ADDR_OPT3, 8'h13, RESP_OKAY);
    rx(8'h13, 1'b0);
    rq(2, {1'b1, EXC_STOP}, 9'h013);
    st(6'b011011);
    n = rm.sent.size();
    cmd(8'h02);
    wait_sent(n + 1);
    chk(rm.sent[n], 8'h13, "stop sent while halted");
    n = rm.sent.size();
    tx_fifo_valid <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(tx_fifo_ready, 1'b0, "fifo held while stopped");
    chk(rm.sent.size(), n, "nothing sent while stopped");
    tx_fifo_valid <= 1'b0;
    rx(8'h41, 1'b0);
    rq(1, 9'h041, 9'h0);
    st(6'b011011);
    rx(8'h11, 1'b0);
    rq(2, {1'b1, EXC_RESUME}, 9'h011);
    st(6'b101011);
    tx_fifo_valid <= 1'b1;
    wait_sent(n + 1);
    tx_fifo_valid <= 1'b0;
    st(6'b001011);
  endtask : t_auto

  task automatic t_modes;
    wr(ADDR_OPT3, 8'h33, RESP_OKAY);
    rx(8'h13, 1'b0);
    rq(0, 9'h0, 9'h0);
    st(6'b011011);
    wr(ADDR_OPT2, 8'hC0, RESP_OKAY);
    rx(8'h41, 1'b0);
    rq(1, 9'h041, 9'h0);
    st(6'b001011);
    rx(8'h13, 1'b0);
    st(6'b011011);
    cmd(8'h20);
    st(6'b000011);
    cmd(8'h10);
    st(6'b001011);
    wr(ADDR_OPT2, 8'h40, RESP_OKAY);
    wr(ADDR_OPT3, 8'h03, RESP_OKAY);
    rx(8'h13, 1'b0);
    rq(1, 9'h013, 9'h0);
    st(6'b001011);
    wr(ADDR_OPT3, 8'h13, RESP_OKAY);
    rx(8'h13, 1'b1);
    rxq.delete();
    st(6'b001011);
    wr(ADDR_OPT5, 8'h01, RESP_OKAY);
    rx(8'h13, 1'b1);
    rxq.delete();
    st(6'b011011);
    // five-bit length: only the low five bits take part in the match
    wr(ADDR_OPT3, 8'h10, RESP_OKAY);
    rx(8'hF3, 1'b0);
    rq(2, {1'b1, EXC_STOP}, 9'h0F3);
  endtask : t_modes

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // main sequence; every input has a value before the first edge
  initial
  begin
    reset_n       = 1'b0;
    awvalid       = 1'b0;
    wvalid        = 1'b0;
    bready        = 1'b0;
    arvalid       = 1'b0;
    rready        = 1'b0;
    awaddr        = 8'h00;
    araddr        = 8'h00;
    wdata         = 32'h0;
    wstrb         = 4'hF;
    rx_char_valid = 1'b0;
    rx_char       = 8'h00;
    rx_char_err   = 1'b0;
    tx_fifo_valid = 1'b0;
    tx_fifo_data  = 8'h00;
    stall         = 1'b0;
    slow          = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_send();
    t_pre();
    t_auto();
    t_modes();
    close_out();
  end

  // the whole run needs a few hundred cycles; this margin only catches a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    $display("BAD %0t watchdog expired", $time);
    fails++;
    close_out();
  end
endmodule : tb_ifc_flow_ctrl
